// *** slx_core.sv ***
// spare-lane enable and sync-header content control for two links
// assumes host writes config only while transmitter_enable is low
//
// Operation
// - link A register bits 7..1 turn on lane n link-layer clock, bit n to lane n.
// - link B register bits 7..1 turn on lane n link-layer clock, bit n to lane n.
// - bit 0 clear gives clocks only, bit 0 set also turns on the spare serializers.
// - requested spare lanes turn on even when the link format leaves them unused.
// - spare lanes use the rate and format of the current link format and test selection.
// - a spare-only lane sends an octet ramp (test 4) when test selection is 0 or 5.
// - a powered-down link keeps its lanes off regardless of spare bits.
// - serializer n is clocked only when lanes 0 to n-1 are enabled.
// - sync field 0 sends CRC-12, 2 sends FEC, 1 and 3 are reserved.
// - each multi-block sync word carries 32 header bits.
// - sync selection acts only in 64b/66b link formats.
// - command fields are sent as zero, idle headers.
//
// Decided for this implementation: the strobed register port.
`default_nettype none
module slx_core #(
  parameter int unsigned LANES = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // link configuration
  input wire logic transmitter_enable_i,
  input wire logic [1:0] channel_power_down_i,
  input wire logic [LANES-1:0] link_a_mode_lanes_i,
  input wire logic [LANES-1:0] link_b_mode_lanes_i,
  input wire logic link_is_64b66b_i,
  input wire logic [3:0] lane_test_pattern_sel_i,
  // lane gates
  output logic [LANES-1:0] link_a_clk_en_o,
  output logic [LANES-1:0] link_a_ser_en_o,
  output logic [LANES-1:0] link_b_clk_en_o,
  output logic [LANES-1:0] link_b_ser_en_o,
  output logic [LANES-1:0] link_a_ramp_o,
  output logic [LANES-1:0] link_b_ramp_o,
  output logic [3:0] lane_pattern_o,
  // sync header
  output logic [1:0] sync_word_kind_o,
  output logic [31:0] sync_cmd_bits_o
);
  // ==========================================================
  // registers
  logic [7:0] link_a_spare_r;
  logic [7:0] link_b_spare_r;
  logic [1:0] sync_word_content_sel_r;
  logic link_a_spare_serializer_on;
  logic link_b_spare_serializer_on;
  slx_pkg::slx_sh_t sh_kind;
  localparam logic [1:0] RST_SYNC_SEL_2 = slx_pkg::RST_SYNC_SEL[1:0];
  localparam slx_pkg::slx_sh_t SLX_IDLE_K = slx_pkg::SLX_SH_IDLE;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      link_a_spare_r <= slx_pkg::RST_SPARE;
      link_b_spare_r <= slx_pkg::RST_SPARE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == slx_pkg::ADDR_LINK_A_SPARE) begin
        link_a_spare_r <= reg_wdata_i;
      end
      if (reg_addr_i == slx_pkg::ADDR_LINK_B_SPARE) begin
        link_b_spare_r <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync_word_content_sel_r <= RST_SYNC_SEL_2;
    end else if (reg_wr_i && reg_addr_i == slx_pkg::ADDR_SYNC_SEL) begin
      sync_word_content_sel_r <= reg_wdata_i[1:0];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        slx_pkg::ADDR_LINK_A_SPARE: reg_rdata_o <= link_a_spare_r;
        slx_pkg::ADDR_LINK_B_SPARE: reg_rdata_o <= link_b_spare_r;
        slx_pkg::ADDR_SYNC_SEL: reg_rdata_o <= {6'h00, sync_word_content_sel_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ==========================================================
  // lane gating
  assign link_a_spare_serializer_on = link_a_spare_r[slx_pkg::SER_ON_BIT];
  assign link_b_spare_serializer_on = link_b_spare_r[slx_pkg::SER_ON_BIT];
  logic [LANES-1:0] a_clk, a_ser, a_only, b_clk, b_ser, b_only;

  slx_lane_gate #(.LANES(LANES)) u_gate_a (
    .spare_req_i(link_a_spare_r[LANES-1:0]),
    .ser_on_i(link_a_spare_serializer_on),
    .mode_lanes_i(link_a_mode_lanes_i),
    .powered_i(~channel_power_down_i[0]),
    .clk_en_o(a_clk),
    .ser_en_o(a_ser),
    .spare_only_o(a_only)
  );
  slx_lane_gate #(.LANES(LANES)) u_gate_b (
    .spare_req_i(link_b_spare_r[LANES-1:0]),
    .ser_on_i(link_b_spare_serializer_on),
    .mode_lanes_i(link_b_mode_lanes_i),
    .powered_i(~channel_power_down_i[1]),
    .clk_en_o(b_clk),
    .ser_en_o(b_ser),
    .spare_only_o(b_only)
  );

  logic ramp_sub;
  assign ramp_sub = (lane_test_pattern_sel_i == slx_pkg::TEST_NONE) ||
                    (lane_test_pattern_sel_i == slx_pkg::TEST_ALT);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      link_a_clk_en_o <= '0;
      link_a_ser_en_o <= '0;
      link_b_clk_en_o <= '0;
      link_b_ser_en_o <= '0;
      link_a_ramp_o <= '0;
      link_b_ramp_o <= '0;
      lane_pattern_o <= slx_pkg::TEST_NONE;
    end else begin
      link_a_clk_en_o <= a_clk;
      link_a_ser_en_o <= a_ser;
      link_b_clk_en_o <= b_clk;
      link_b_ser_en_o <= b_ser;
      link_a_ramp_o <= ramp_sub ? a_only : '0;
      link_b_ramp_o <= ramp_sub ? b_only : '0;
      lane_pattern_o <= lane_test_pattern_sel_i;
    end
  end

  // ==========================================================
  // sync header content
  always_comb begin
    if (!link_is_64b66b_i) begin
      sh_kind = SLX_IDLE_K;
    end else begin
      case (sync_word_content_sel_r)
        slx_pkg::SH_CRC12: sh_kind = slx_pkg::SLX_SH_CRC;
        slx_pkg::SH_FEC: sh_kind = slx_pkg::SLX_SH_FEC;
        default: sh_kind = slx_pkg::SLX_SH_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync_word_kind_o <= 2'h0;
      sync_cmd_bits_o <= 32'h0000_0000;
    end else begin
      sync_word_kind_o <= sh_kind;
      sync_cmd_bits_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  property p_ser_needs_clk;
    @(posedge core_clk_i) disable iff (srst_i)
      1 |-> ((link_a_ser_en_o & ~link_a_clk_en_o) == '0);
  endproperty
  a_ser_needs_clk: assert property (p_ser_needs_clk)
    else $error("serializer on without clock");

  property p_ser_chain;
    @(posedge core_clk_i) disable iff (srst_i)
      link_a_ser_en_o[1] |-> link_a_clk_en_o[0];
  endproperty
  a_ser_chain: assert property (p_ser_chain) else $error("serializer 1 without lane 0");

  property p_pd_a;
    @(posedge core_clk_i) disable iff (srst_i)
      channel_power_down_i[0] |=> (link_a_clk_en_o == '0);
  endproperty
  a_pd_a: assert property (p_pd_a) else $error("link A lanes on while powered down");

  property p_spare_a;
    @(posedge core_clk_i) disable iff (srst_i)
      (link_a_spare_r[3] && !channel_power_down_i[0]) |=> link_a_clk_en_o[3];
  endproperty
  a_spare_a: assert property (p_spare_a) else $error("spare lane A3 not on");

  property p_spare_b;
    @(posedge core_clk_i) disable iff (srst_i)
      (link_b_spare_r[5] && !channel_power_down_i[1]) |=> link_b_clk_en_o[5];
  endproperty
  a_spare_b: assert property (p_spare_b) else $error("spare lane B5 not on");

  property p_off_unused;
    @(posedge core_clk_i) disable iff (srst_i)
      (!link_a_spare_r[2] && !link_a_mode_lanes_i[2]) |=> !link_a_clk_en_o[2];
  endproperty
  a_off_unused: assert property (p_off_unused) else $error("unused lane A2 on");

  property p_ramp;
    @(posedge core_clk_i) disable iff (srst_i)
      (lane_test_pattern_sel_i == slx_pkg::TEST_RAMP) |=> (link_a_ramp_o == '0);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp flag outside test 0 or 5");

  property p_8b10b;
    @(posedge core_clk_i) disable iff (srst_i)
      !link_is_64b66b_i |=> (sync_word_kind_o == 2'h0);
  endproperty
  a_8b10b: assert property (p_8b10b) else $error("sync kind set in 8b/10b");

  property p_cmd_zero;
    @(posedge core_clk_i) disable iff (srst_i)
      1 |-> (sync_cmd_bits_o == 32'h0000_0000);
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command bits not zero");

  property p_ser_clk_b;
    @(posedge core_clk_i) disable iff (srst_i)
      1 |-> ((link_b_ser_en_o & ~link_b_clk_en_o) == '0);
  endproperty
  a_ser_clk_b: assert property (p_ser_clk_b) else $error("B serializer without clock");

  property p_pd_b;
    @(posedge core_clk_i) disable iff (srst_i)
      channel_power_down_i[1] |=> ((link_b_clk_en_o | link_b_ser_en_o) == '0);
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("link B lanes on while powered down");

  property p_off_unused_b;
    @(posedge core_clk_i) disable iff (srst_i)
      (!link_b_spare_r[4] && !link_b_mode_lanes_i[4]) |=>
        (!link_b_clk_en_o[4] && !link_b_ser_en_o[4]);
  endproperty
  a_off_unused_b: assert property (p_off_unused_b) else $error("unused lane B4 on");

  property p_lane0_mode;
    @(posedge core_clk_i) disable iff (srst_i)
      !link_a_mode_lanes_i[0] |=> !link_a_clk_en_o[0];
  endproperty
  a_lane0_mode: assert property (p_lane0_mode) else $error("lane A0 on outside mode");

  property p_spare_unused;
    @(posedge core_clk_i) disable iff (srst_i)
      (link_a_spare_r[2] && !link_a_mode_lanes_i[2] && !channel_power_down_i[0]) |=>
        link_a_clk_en_o[2];
  endproperty
  a_spare_unused: assert property (p_spare_unused) else $error("spare lane A2 not on");

  property p_clk_only;
    @(posedge core_clk_i) disable iff (srst_i)
      (!link_a_spare_r[0] && !link_a_mode_lanes_i[2]) |=> !link_a_ser_en_o[2];
  endproperty
  a_clk_only: assert property (p_clk_only) else $error("lane A2 serializing");

  property p_ser_chain_b;
    @(posedge core_clk_i) disable iff (srst_i)
      link_b_ser_en_o[4] |-> (link_b_ser_en_o[3] && link_b_clk_en_o[3]);
  endproperty
  a_ser_chain_b: assert property (p_ser_chain_b) else $error("B4 without B3");

  property p_ramp_alt;
    @(posedge core_clk_i) disable iff (srst_i)
      (lane_test_pattern_sel_i == slx_pkg::TEST_ALT && link_a_spare_r[2] &&
       !link_a_mode_lanes_i[2] && !channel_power_down_i[0]) |=> link_a_ramp_o[2];
  endproperty
  a_ramp_alt: assert property (p_ramp_alt) else $error("no ramp on spare lane A2");

  property p_ramp_b;
    @(posedge core_clk_i) disable iff (srst_i)
      (lane_test_pattern_sel_i == slx_pkg::TEST_RAMP) |=> (link_b_ramp_o == '0);
  endproperty
  a_ramp_b: assert property (p_ramp_b) else $error("B ramp flag outside test 0 or 5");

  property p_pattern;
    @(posedge core_clk_i) disable iff (srst_i)
      1 |=> (lane_pattern_o == $past(lane_test_pattern_sel_i));
  endproperty
  a_pattern: assert property (p_pattern) else $error("lane pattern not followed");

  property p_fec;
    @(posedge core_clk_i) disable iff (srst_i)
      (link_is_64b66b_i && sync_word_content_sel_r == slx_pkg::SH_FEC) |=>
        (sync_word_kind_o == slx_pkg::SLX_SH_FEC);
  endproperty
  a_fec: assert property (p_fec) else $error("FEC not selected");

  property p_reserved;
    @(posedge core_clk_i) disable iff (srst_i)
      (link_is_64b66b_i && sync_word_content_sel_r[0]) |=>
        (sync_word_kind_o == slx_pkg::SLX_SH_IDLE);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved sync code not idle");

  property p_read_a;
    @(posedge core_clk_i) disable iff (srst_i)
      (reg_rd_i && reg_addr_i == slx_pkg::ADDR_LINK_A_SPARE) |=>
        (reg_rdata_o == $past(link_a_spare_r));
  endproperty
  a_read_a: assert property (p_read_a) else $error("link A register read wrong");

  // write of lane 1 spare bit, then a powered cycle, then the clock gate
  sequence s_spare_a1_write;
    reg_wr_i && (reg_addr_i == slx_pkg::ADDR_LINK_A_SPARE) && reg_wdata_i[1];
  endsequence
  sequence s_link_a_up;
    !channel_power_down_i[0];
  endsequence

  property p_spare_write;
    @(posedge core_clk_i) disable iff (srst_i)
      s_spare_a1_write ##1 s_link_a_up |=> link_a_clk_en_o[1];
  endproperty
  a_spare_write: assert property (p_spare_write) else $error("spare lane A1 write lost");
endmodule : slx_core
`default_nettype wire

// *** slx_pkg.sv ***
// package for spare-lane and sync-header control block
// assumes one 20 MHz clock and an 8-bit register port
`default_nettype none
package slx_pkg;
  localparam int unsigned LANES = 8;
  localparam logic [9:0] ADDR_LINK_A_SPARE = 10'h20a;
  localparam logic [9:0] ADDR_LINK_B_SPARE = 10'h20b;
  localparam logic [9:0] ADDR_SYNC_SEL = 10'h20f;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [7:0] RST_SYNC_SEL = 8'h00;
  localparam int unsigned SER_ON_BIT = 0;
  localparam logic [1:0] SH_CRC12 = 2'h0;
  localparam logic [1:0] SH_FEC = 2'h2;
  localparam logic [3:0] TEST_NONE = 4'h0;
  localparam logic [3:0] TEST_RAMP = 4'h4;
  localparam logic [3:0] TEST_ALT = 4'h5;
  typedef enum logic [1:0] {
    SLX_SH_IDLE,
    SLX_SH_CRC,
    SLX_SH_FEC
  } slx_sh_t;
endpackage : slx_pkg
`default_nettype wire

// *** slx_lane_gate.sv ***
// gating of one link's lane clocks and serializers
// assumes mode lane mask and power state arrive synchronous to clk
`default_nettype none
module slx_lane_gate #(
  parameter int unsigned LANES = 8
) (
  // spare-lane control
  input wire logic [LANES-1:0] spare_req_i,
  input wire logic ser_on_i,
  // link state
  input wire logic [LANES-1:0] mode_lanes_i,
  input wire logic powered_i,
  // gates
  output logic [LANES-1:0] clk_en_o,
  output logic [LANES-1:0] ser_en_o,
  output logic [LANES-1:0] spare_only_o
);
  logic [LANES-1:0] want;
  logic [LANES-1:0] ser_want;
  always_comb begin
    want = (mode_lanes_i | {spare_req_i[LANES-1:1], 1'b0})
           & {LANES{powered_i}};
    clk_en_o = want;
    spare_only_o = want & ~mode_lanes_i;
    ser_want = mode_lanes_i | (ser_on_i ? want : '0);
    ser_want = ser_want & want;
    ser_en_o[0] = ser_want[0];
    for (int n = 1; n < LANES; n++) begin
      ser_en_o[n] = ser_want[n] & ser_en_o[n-1] & want[n-1];
    end
  end
endmodule : slx_lane_gate
`default_nettype wire

// *** slx_rx_model.sv ***
// far-side lane receiver model for the spare-lane block
// assumes lane gates are level signals on the core clock
`default_nettype none
module slx_rx_model #(
  parameter int unsigned LANES = 8
) (
  // lane gates from the transmitter
  input wire logic [LANES-1:0] clk_en_i,
  input wire logic [LANES-1:0] ser_en_i,
  // lanes that carry data
  output logic [LANES-1:0] live_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a serializer without its link clock sends nothing
  assign live_o = clk_en_i & ser_en_i;
endmodule : slx_rx_model
`default_nettype wire

// *** test_slx_core.sv ***
// self-checking bench for the spare-lane and sync-header block
// assumes a 20 MHz core clock and the one-cycle register port
`default_nettype none
module test_slx_core;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic srst_i = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic tx_en = 1'b0; // writes only while disabled
  logic [1:0] pd = 2'h0;
  logic [7:0] ma = 8'h00;
  logic [7:0] mb = 8'h00;
  logic sh64 = 1'b0;
  logic [3:0] tsel = 4'h0;
  logic [7:0] rdata, a_clk, a_ser, b_clk, b_ser, a_ramp, b_ramp, a_live;
  logic [3:0] pat;
  logic [1:0] kind;
  logic [31:0] cmd;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  slx_core #(.LANES(8)) i_slx_core (.core_clk_i(clk), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .transmitter_enable_i(tx_en), .channel_power_down_i(pd), .link_a_mode_lanes_i(ma),
    .link_b_mode_lanes_i(mb), .link_is_64b66b_i(sh64), .lane_test_pattern_sel_i(tsel),
    .link_a_clk_en_o(a_clk), .link_a_ser_en_o(a_ser), .link_b_clk_en_o(b_clk),
    .link_b_ser_en_o(b_ser), .link_a_ramp_o(a_ramp), .link_b_ramp_o(b_ramp),
    .lane_pattern_o(pat), .sync_word_kind_o(kind), .sync_cmd_bits_o(cmd));
  slx_rx_model #(.LANES(8)) i_slx_rx_model (.clk_en_i(a_clk), .ser_en_i(a_ser),
    .live_o(a_live));
  // ==========================================================
  // shared tasks
  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk("read data", {24'h0, exp}, {24'h0, rdata});
  endtask : rd
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // ==========================================================
  // scenarios
  task t_regs;
    rd(slx_pkg::ADDR_LINK_A_SPARE, slx_pkg::RST_SPARE);
    rd(slx_pkg::ADDR_LINK_B_SPARE, slx_pkg::RST_SPARE);
    rd(slx_pkg::ADDR_SYNC_SEL, slx_pkg::RST_SYNC_SEL);
    wr(slx_pkg::ADDR_SYNC_SEL, 8'hff);
    rd(slx_pkg::ADDR_SYNC_SEL, 8'h03);
    wr(10'h20c, 8'h5a);
    rd(10'h20c, 8'h00);
    wr(slx_pkg::ADDR_LINK_A_SPARE, 8'h5a);
    rd(slx_pkg::ADDR_LINK_A_SPARE, 8'h5a);
    wr(slx_pkg::ADDR_LINK_B_SPARE, 8'ha5);
    rd(slx_pkg::ADDR_LINK_B_SPARE, 8'ha5);
  endtask : t_regs
  task t_lane(input logic b, input logic [3:0] ts, input logic [1:0] p,
              input logic [7:0] m, input logic [7:0] r, input logic [7:0] eclk,
              input logic [7:0] eser);
    logic [7:0] eramp;
    eramp = (ts == slx_pkg::TEST_NONE || ts == slx_pkg::TEST_ALT) ? (eclk & ~m) : 8'h00;
    @(posedge clk);
    tsel <= ts;
    pd <= p;
    if (b) mb <= m;
    else ma <= m;
    wr(b ? slx_pkg::ADDR_LINK_B_SPARE : slx_pkg::ADDR_LINK_A_SPARE, r);
    settle();
    chk("clock enables", {24'h0, eclk}, {24'h0, b ? b_clk : a_clk});
    chk("serializer enables", {24'h0, eser}, {24'h0, b ? b_ser : a_ser});
    chk("ramp lanes", {24'h0, eramp}, {24'h0, b ? b_ramp : a_ramp});
    chk("pattern", {28'h0, ts}, {28'h0, pat});
    if (!b) chk("live lanes", {24'h0, eclk & eser}, {24'h0, a_live});
  endtask : t_lane
  task t_reset;
    @(posedge clk);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("clocks in reset", 32'h0000_0000, {24'h0, a_clk});
    chk("serializers in reset", 32'h0000_0000, {24'h0, b_ser});
    @(posedge clk);
    srst_i <= 1'b0;
    rd(slx_pkg::ADDR_LINK_A_SPARE, slx_pkg::RST_SPARE);
    rd(slx_pkg::ADDR_SYNC_SEL, slx_pkg::RST_SYNC_SEL);
  endtask : t_reset
  task t_sync(input logic is64, input logic [1:0] code, input logic [1:0] ekind);
    @(posedge clk);
    sh64 <= is64;
    wr(slx_pkg::ADDR_SYNC_SEL, {6'h00, code});
    settle();
    chk("sync kind", {30'h0, ekind}, {30'h0, kind});
    chk("command bits", 32'h0000_0000, cmd);
  endtask : t_sync
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst_i <= 1'b0;
    t_regs();
    t_lane(1'b0, 4'h0, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00);
    t_lane(1'b0, 4'h0, 2'h0, 8'h01, 8'h07, 8'h07, 8'h07);
    t_lane(1'b0, 4'h0, 2'h0, 8'h01, 8'h06, 8'h07, 8'h01);
    t_lane(1'b0, 4'h0, 2'h0, 8'h01, 8'h09, 8'h09, 8'h01);
    t_lane(1'b1, 4'h0, 2'h0, 8'h03, 8'hf1, 8'hf3, 8'h03);
    t_lane(1'b0, 4'h5, 2'h0, 8'h01, 8'h07, 8'h07, 8'h07);
    t_lane(1'b0, 4'h1, 2'h0, 8'h01, 8'h07, 8'h07, 8'h07);
    t_lane(1'b0, 4'h0, 2'h1, 8'h01, 8'h07, 8'h00, 8'h00);
    chk("link b clocks", 32'h0000_00f3, {24'h0, b_clk});
    t_lane(1'b1, 4'h0, 2'h2, 8'h03, 8'hf1, 8'h00, 8'h00);
    chk("link a clocks", 32'h0000_0007, {24'h0, a_clk});
    t_lane(1'b1, 4'h4, 2'h0, 8'h03, 8'hf1, 8'hf3, 8'h03);
    t_reset();
    t_sync(1'b1, 2'h0, slx_pkg::SLX_SH_CRC);
    t_sync(1'b1, 2'h1, slx_pkg::SLX_SH_IDLE);
    t_sync(1'b1, 2'h2, slx_pkg::SLX_SH_FEC);
    t_sync(1'b1, 2'h3, slx_pkg::SLX_SH_IDLE);
    t_sync(1'b0, 2'h2, slx_pkg::SLX_SH_IDLE);
    close_out();
  end
endmodule : test_slx_core
`default_nettype wire
